// ===== hdl/spdl_pkg.sv
package spdl_pkg;
   localparam int SPDL_DAC_W = 12;
   localparam int SPDL_NUM_DAC = 4;
   localparam int SPDL_CMD_W = 8;
   localparam int SPDL_WORD_W = 32;
   localparam logic [11:0] SPDL_DAC_HIGH = 12'hfff;
   localparam logic [11:0] SPDL_DAC_LOW = 12'h000;
   localparam logic [1:0] SPDL_CKMODE_RISE = 2'h3;
   localparam int SPDL_FIFO_DEPTH = 4;
   // word field layout: command byte in [31:24], payload follows msb first
   localparam int SPDL_CMD_LSB = 24;

   typedef struct packed {
      logic [5:0] nbits;
      logic [SPDL_WORD_W-1:0] bits;
   } spdl_word_t;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
   } spdl_pins_t;
endpackage

// ===== hdl/spdl_port.sv
`timescale 1ns/1ps
module spdl_fifo #(
   parameter int WIDTH = 38,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wp_r, rp_r, wp_nxt, rp_nxt;
   logic push, pop;
   always_comb begin
      in_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
      out_valid = wp_r != rp_r;
      out_data = mem_r[rp_r[AW-1:0]];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r[AW-1:0]] <= in_data;
      end
   end
endmodule

module spdl_port #(
   parameter int NUM_DAC = spdl_pkg::SPDL_NUM_DAC,
   parameter int FIFO_DEPTH = spdl_pkg::SPDL_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rstn,
   input wire spdl_pkg::spdl_pins_t pins_in,
   output logic dout_o,
   output logic dout_oe,
   input wire logic [1:0] clock_mode,
   input wire logic [spdl_pkg::SPDL_DAC_W-1:0] result_data,
   input wire logic result_valid,
   output logic result_taken,
   output logic eoc_n,
   input wire logic dac_load_n,
   input wire logic dac_powerup_select,
   input wire logic [1:0] dac_wr_sel,
   input wire logic [spdl_pkg::SPDL_DAC_W-1:0] dac_wr_data,
   input wire logic dac_wr_en,
   output logic [NUM_DAC*spdl_pkg::SPDL_DAC_W-1:0] dac_out,
   output logic word_valid,
   input wire logic word_ready,
   output spdl_pkg::spdl_word_t word_data
);
   import spdl_pkg::*;
   localparam int WW = $bits(spdl_word_t);
   typedef enum logic [1:0] {
      SPDL_IDLE = 2'b00,
      SPDL_SHIFT = 2'b01,
      SPDL_DONE = 2'b10
   } spdl_state_t;
   // two-flop synchronisers; only the second stage is read
   logic [2:0] s1_r, s2_r;
   logic cs_n_s, sclk_s, din_s, sclk_d;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_r <= 3'h5;
         s2_r <= 3'h5;
         sclk_d <= 1'b0;
      end else begin
         s1_r <= pins_in;
         s2_r <= s1_r;
         sclk_d <= s2_r[1];
      end
   end
   assign {cs_n_s, sclk_s, din_s} = s2_r;
   logic fall, rise, shift_edge;
   assign fall = !cs_n_s && sclk_d && !sclk_s;
   assign rise = !cs_n_s && !sclk_d && sclk_s;
   assign shift_edge = (clock_mode == SPDL_CKMODE_RISE) ? rise : fall;
   spdl_state_t st_r, st_nxt;
   logic [SPDL_WORD_W-1:0] sh_r, sh_nxt;
   logic [5:0] cnt_r, cnt_nxt;
   logic [SPDL_DAC_W-1:0] tx_r, tx_nxt;
   logic dout_r, dout_nxt, oe_r, oe_nxt, eoc_r, eoc_nxt, tk_r, tk_nxt;
   logic push, f_ready;
   spdl_word_t push_w;
   always_comb begin
      st_nxt = st_r;
      sh_nxt = sh_r;
      cnt_nxt = cnt_r;
      tx_nxt = tx_r;
      dout_nxt = dout_r;
      eoc_nxt = eoc_r;
      tk_nxt = 1'b0;
      push = 1'b0;
      push_w = '{nbits: cnt_r, bits: sh_r};
      oe_nxt = !cs_n_s;
      case (st_r)
         SPDL_IDLE: begin
            if (!cs_n_s) begin
               st_nxt = SPDL_SHIFT;
               cnt_nxt = '0;
               sh_nxt = '0;
            end
         end
         SPDL_SHIFT: begin
            if (cs_n_s) begin
               // whole bytes only go forward
               st_nxt = SPDL_IDLE;
               if (cnt_r >= 6'(SPDL_CMD_W) && cnt_r[2:0] == 3'h0) begin
                  st_nxt = SPDL_DONE;
               end
            end else if (fall && cnt_r != 6'(SPDL_WORD_W)) begin
               // msb first, left aligned on the command byte
               sh_nxt[SPDL_WORD_W-1-cnt_r[4:0]] = din_s;
               cnt_nxt = cnt_r + 6'h1;
            end
            if (shift_edge) begin
               dout_nxt = tx_r[SPDL_DAC_W-1];
               tx_nxt = {tx_r[SPDL_DAC_W-2:0], 1'b0};
               eoc_nxt = 1'b1;
            end
         end
         SPDL_DONE: begin
            push = 1'b1;
            // a full fifo stalls here, holding the next frame off
            if (f_ready) begin
               st_nxt = SPDL_IDLE;
            end
         end
         default: st_nxt = SPDL_IDLE;
      endcase
      // a load wins over a shift edge, so a taken result is never lost
      if (result_valid && eoc_r) begin
         tx_nxt = result_data;
         eoc_nxt = 1'b0;
         tk_nxt = 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= SPDL_IDLE;
         sh_r <= '0;
         cnt_r <= '0;
         tx_r <= '0;
         dout_r <= 1'b0;
         oe_r <= 1'b0;
         eoc_r <= 1'b1;
         tk_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         sh_r <= sh_nxt;
         cnt_r <= cnt_nxt;
         tx_r <= tx_nxt;
         dout_r <= dout_nxt;
         oe_r <= oe_nxt;
         eoc_r <= eoc_nxt;
         tk_r <= tk_nxt;
      end
   end
   assign dout_o = dout_r;
   assign dout_oe = oe_r;
   assign eoc_n = eoc_r;
   assign result_taken = tk_r;
   // output stage register keeps outputs straight from flops
   logic fv, f_pop, wv_r, wv_nxt;
   logic [WW-1:0] fd;
   spdl_word_t wd_r, wd_nxt;
   spdl_fifo #(.WIDTH(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rstn(rstn),
      .in_valid(push),
      .in_ready(f_ready),
      .in_data(push_w),
      .out_valid(fv),
      .out_ready(f_pop),
      .out_data(fd)
   );
   always_comb begin
      f_pop = fv && (!wv_r || word_ready);
      wv_nxt = wv_r && !word_ready;
      wd_nxt = wd_r;
      if (f_pop) begin
         wv_nxt = 1'b1;
         wd_nxt = fd;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wv_r <= 1'b0;
         wd_r <= '0;
      end else begin
         wv_r <= wv_nxt;
         wd_r <= wd_nxt;
      end
   end
   assign word_valid = wv_r;
   assign word_data = wd_r;
   // dac input and dac registers
   logic [SPDL_DAC_W-1:0] in_r [NUM_DAC];
   logic [SPDL_DAC_W-1:0] dac_r [NUM_DAC];
   logic ld1_r, ld2_r, init_r, sel1_r, sel2_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ld1_r <= 1'b1;
         ld2_r <= 1'b1;
         init_r <= 1'b1;
      end else begin
         ld1_r <= dac_load_n;
         ld2_r <= ld1_r;
         init_r <= 1'b0;
      end
   end
   // strap sync is left unreset so it already holds the pin when reset lifts
   always_ff @(posedge clk) begin
      sel1_r <= dac_powerup_select;
      sel2_r <= sel1_r;
   end
   genvar g;
   generate
      for (g = 0; g < NUM_DAC; g++) begin : g_dac
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               in_r[g] <= SPDL_DAC_LOW;
               dac_r[g] <= SPDL_DAC_LOW;
            end else if (init_r) begin
               // strap caught once after release
               in_r[g] <= sel2_r ? SPDL_DAC_HIGH : SPDL_DAC_LOW;
               dac_r[g] <= sel2_r ? SPDL_DAC_HIGH : SPDL_DAC_LOW;
            end else begin
               if (dac_wr_en && dac_wr_sel == 2'(g)) begin
                  in_r[g] <= dac_wr_data;
               end
               if (!ld2_r) begin
                  dac_r[g] <= in_r[g];
               end
            end
         end
         assign dac_out[g*SPDL_DAC_W +: SPDL_DAC_W] = dac_r[g];
      end
   endgenerate

   a_oe_follows_cs: assert property (@(posedge clk) disable iff (!rstn)
      cs_n_s |=> !dout_oe) else $error("dout driven while deselected");
   a_idle_no_count: assert property (@(posedge clk) disable iff (!rstn)
      cs_n_s && st_r == SPDL_SHIFT |=> st_r != SPDL_SHIFT)
      else $error("port not reset by chip select");
   a_count_on_fall: assert property (@(posedge clk) disable iff (!rstn)
      st_r == SPDL_SHIFT && !cs_n_s && !fall |=> $stable(cnt_r))
      else $error("bit taken without falling edge");
   a_shift_rise: assert property (@(posedge clk) disable iff (!rstn)
      st_r == SPDL_SHIFT && clock_mode == SPDL_CKMODE_RISE && fall && !rise
      |=> $stable(tx_r) || $fell(eoc_r))
      else $error("mode 11 shifted on fall");
   a_shift_fall: assert property (@(posedge clk) disable iff (!rstn)
      st_r == SPDL_SHIFT && clock_mode != SPDL_CKMODE_RISE && rise
      |=> $stable(tx_r) || $fell(eoc_r))
      else $error("shifted on rise");
   a_eoc_falls: assert property (@(posedge clk) disable iff (!rstn)
      result_valid && eoc_r && st_r == SPDL_IDLE |=> !eoc_r && result_taken)
      else $error("eoc not asserted");
   a_dac_transp: assert property (@(posedge clk) disable iff (!rstn)
      !ld2_r && !init_r |=> dac_r[0] == $past(in_r[0]))
      else $error("dac not transparent");
   a_dac_init: assert property (@(posedge clk) disable iff (!rstn)
      init_r |=> in_r[0] == ($past(sel2_r) ? SPDL_DAC_HIGH : SPDL_DAC_LOW))
      else $error("bad power-up code");
   a_strap_once: assert property (@(posedge clk) disable iff (!rstn)
      !init_r && !dac_wr_en |=> $stable(in_r[0]))
      else $error("strap changed dac");
endmodule

// ===== tb/spdl_host.sv
`timescale 1ns/1ps
module spdl_host (
   output spdl_pkg::spdl_pins_t pins,
   input wire logic dout,
   input wire logic dout_oe
);
   import spdl_pkg::*;
   initial pins = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
   // cs falls first, then n bits msb first
   task automatic frame(input logic [31:0] d, input int n, input logic m3,
                        output logic [11:0] rd, output logic oe);
      rd = '0;
      oe = 1'b1;
      // keep pin changes off the sampling clock edge
      #2;
      pins.sclk = m3;
      pins.cs_n = 1'b0;
      pins.din = d[31];
      #40;
      for (int i = 0; i < n; i++) begin
         pins.sclk = ~m3;
         #40;
         // read just before the shift edge while the old bit still stands;
         // read 0 precedes any shift, reads 1 to 12 carry the result
         if (i >= 1 && i <= 12) rd = {rd[10:0], dout};
         oe = oe & dout_oe;
         pins.sclk = m3;
         #20;
         pins.din = (i < 31) ? d[30-i] : ~d[0];
         #20;
      end
      // released data line shows the inverse, not the next bit
      pins.din = ~pins.din;
      #40;
      pins.cs_n = 1'b1;
      #200;
   endtask
   task automatic noise();
      #2;
      repeat (8) begin
         pins.sclk = ~pins.sclk;
         pins.din = ~pins.din;
         #40;
      end
   endtask
endmodule

// ===== tb/spdl_port_tb.sv
`timescale 1ns/1ps
module spdl_port_tb;
   import spdl_pkg::*;
   logic clk, rstn, result_valid, result_taken, eoc_n, dout_o, dout_oe;
   logic dac_load_n, dac_powerup_select, dac_wr_en, word_valid, word_ready;
   logic [1:0] clock_mode, dac_wr_sel;
   logic [SPDL_DAC_W-1:0] result_data, dac_wr_data;
   logic [4*SPDL_DAC_W-1:0] dac_out;
   spdl_pins_t pins;
   spdl_word_t word_data;
   logic [11:0] rd;
   logic oe;
   int fails = 0;
   int n_checks = 0;
   spdl_port uut (.clk(clk), .rstn(rstn), .pins_in(pins), .dout_o(dout_o),
      .dout_oe(dout_oe), .clock_mode(clock_mode), .result_data(result_data),
      .result_valid(result_valid), .result_taken(result_taken),
      .eoc_n(eoc_n), .dac_load_n(dac_load_n),
      .dac_powerup_select(dac_powerup_select), .dac_wr_sel(dac_wr_sel),
      .dac_wr_data(dac_wr_data), .dac_wr_en(dac_wr_en), .dac_out(dac_out),
      .word_valid(word_valid), .word_ready(word_ready),
      .word_data(word_data));
   spdl_host host (.pins(pins), .dout(dout_o), .dout_oe(dout_oe));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic end_sim();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic do_rst(input logic strap);
      rstn <= 1'b0;
      dac_powerup_select <= strap;
      cyc(12);
      rstn <= 1'b1;
      cyc(4);
   endtask
   task automatic get_word(input logic [5:0] nb, input logic [31:0] b);
      int k;
      // settle past the edge that may have just popped the previous word
      @(negedge clk);
      for (k = 0; k < 400 && word_valid !== 1'b1; k++) @(negedge clk);
      if (k == 400) begin
         fails++;
         end_sim();
      end
      chk(word_data, {nb, b});
      @(posedge clk) word_ready <= 1'b1;
      @(posedge clk) word_ready <= 1'b0;
   endtask
   task automatic t_powerup();
      do_rst(1'b1);
      chk(dac_out, {4{SPDL_DAC_HIGH}});
      chk({dout_oe, eoc_n, word_valid}, 3'b010);
      dac_powerup_select <= 1'b0;
      cyc(10);
      chk(dac_out, {4{SPDL_DAC_HIGH}});
      do_rst(1'b0);
      chk(dac_out, {4{SPDL_DAC_LOW}});
      $display("test powerup done");
   endtask
   task automatic t_dac();
      dac_wr_sel <= 2'h2;
      dac_wr_data <= 12'h5a7;
      dac_wr_en <= 1'b1;
      cyc(1);
      dac_wr_en <= 1'b0;
      cyc(8);
      chk(dac_out, 48'h0);
      dac_load_n <= 1'b0;
      cyc(8);
      chk(dac_out, {12'h000, 12'h5a7, 24'h0});
      dac_load_n <= 1'b1;
      $display("test dac done");
   endtask
   task automatic t_frames();
      host.frame(32'ha53c0000, 16, 1'b0, rd, oe);
      chk(oe, 1'b1);
      get_word(6'd16, 32'ha53c0000);
      host.noise();
      host.frame(32'hfff00000, 12, 1'b0, rd, oe);
      host.frame(32'hc3000000, 8, 1'b0, rd, oe);
      get_word(6'd8, 32'hc3000000);
      @(negedge clk);
      chk(word_valid, 1'b0);
      $display("test frames done");
   endtask
   task automatic t_result();
      logic [11:0] v [4] = '{12'hb4d, 12'h6a9, 12'h3c6, 12'h81e};
      int k;
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         clock_mode <= 2'(m);
         result_data <= v[m];
         result_valid <= 1'b1;
         for (k = 0; k < 50 && eoc_n !== 1'b0; k++) @(negedge clk);
         chk(eoc_n, 1'b0);
         chk(result_taken, 1'b1);
         @(posedge clk) result_valid <= 1'b0;
         host.frame(32'h0, 16, m == 3, rd, oe);
         chk(rd, v[m]);
         chk(eoc_n, 1'b1);
         get_word(6'd16, 32'h0);
      end
      $display("test result done");
   endtask
   task automatic t_fifo();
      for (int i = 0; i < 5; i++)
         host.frame({8'h10 + 8'(i), 24'h0}, 8, 1'b0, rd, oe);
      @(negedge clk);
      chk(word_valid, 1'b1);
      for (int i = 0; i < 5; i++)
         get_word(6'd8, {8'h10 + 8'(i), 24'h0});
      @(negedge clk);
      chk({word_valid, dout_oe}, 2'b00);
      $display("test fifo done");
   endtask
   initial begin
      rstn = 1'b0;
      word_ready = 1'b0;
      clock_mode = 2'h0;
      result_valid = 1'b0;
      result_data = '0;
      dac_load_n = 1'b1;
      dac_powerup_select = 1'b1;
      dac_wr_sel = 2'h0;
      dac_wr_data = '0;
      dac_wr_en = 1'b0;
      t_powerup();
      t_dac();
      t_frames();
      t_result();
      t_fifo();
      end_sim();
   end
endmodule
